// file: src/fap_gate.sv
// flash access protection gate: mode decode, boot and debugger access control
//
// Operation
// - ctrl FFh and all id FFh disables protection
// - open, blank flash: boot gets full access
// - open, data present: boot erase-ready until erased
// - open: debugger accepted without id check
// - other ctrl codes except 45h and 52h select debugger-authenticated mode
// - debugger-auth mode: boot always enters erase-ready
// - debugger id must match stored id to connect
// - debugger mismatch refuses, retries, never erase-ready
// - 45h boot id check, three fails erase-ready
`timescale 1ns/10ps
module fap_gate
  import fap_pkg::*;
(
  // clock and reset
  input  wire logic               ref_clk_in,
  input  wire logic               rst_n_in,
  // stored protection codes from the option area
  input  wire logic               cfg_load_in,
  input  wire logic [7:0]         ctrl_code_in,
  input  wire logic [ID_BITS-1:0] id_code_in,
  // flash state
  input  wire logic               flash_blank_in,
  input  wire logic               all_erased_in,
  // boot-mode host
  input  wire logic               boot_connect_in,
  input  wire logic               boot_id_valid_in,
  input  wire logic [ID_BITS-1:0] boot_id_in,
  // on-chip debugger
  input  wire logic               dbg_connect_in,
  input  wire logic [ID_BITS-1:0] dbg_id_in,
  // session end, returns both paths to idle, except that a boot erase-ready lock holds
  input  wire logic               session_end_in,
  // access grants and status
  output logic                    read_ok_out,
  output logic                    prog_ok_out,
  output logic                    erase_ok_out,
  output logic                    erase_ready_out,
  output logic                    boot_auth_wait_out,
  output logic                    boot_refuse_out,
  output logic                    dbg_conn_out,
  output logic                    dbg_refuse_out,
  output logic [1:0]              mode_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic       loaded;
  logic [7:0] ctrl_code;
  logic       id_all_open;
  logic       dbg_done;
  logic       dbg_match;
  logic       boot_done;
  logic       boot_match;
  wire        dbg_start;
  wire        boot_try;

  fap_id_store u_store (
    .ref_clk_in      (ref_clk_in),
    .rst_n_in        (rst_n_in),
    .load_in         (cfg_load_in),
    .ctrl_code_in    (ctrl_code_in),
    .id_code_in      (id_code_in),
    .dbg_valid_in    (dbg_start),
    .dbg_id_in       (dbg_id_in),
    .boot_valid_in   (boot_try),
    .boot_id_in      (boot_id_in),
    .loaded_out      (loaded),
    .ctrl_code_out   (ctrl_code),
    .id_all_open_out (id_all_open),
    .dbg_done_out    (dbg_done),
    .dbg_match_out   (dbg_match),
    .boot_done_out   (boot_done),
    .boot_match_out  (boot_match)
  );

  ////////////////////////////////////////////////////////////////////////////
  fap_mode_t mode;
  wire       is_open;

  assign is_open = (ctrl_code == CTRL_OPEN) && id_all_open;
  assign mode = is_open                      ? MODE_OPEN      :
                (ctrl_code == CTRL_BOOT_LCK) ? MODE_BOOT_LOCK :
                (ctrl_code == CTRL_BOOT_ID)  ? MODE_BOOT_AUTH : MODE_DBG_AUTH;
  assign mode_out = mode;

  ////////////////////////////////////////////////////////////////////////////
  fap_boot_t  boot_q;
  fap_boot_t  boot_d;
  logic [1:0] fail_q;
  logic [1:0] fail_d;
  logic       dbg_busy_q;
  logic       dbg_conn_q;
  logic       dbg_conn_d;
  wire        boot_start;
  wire        boot_fail;
  wire        lock_trip;

  // nothing accepted before the codes are latched
  assign boot_start = loaded && boot_connect_in && (boot_q == BOOT_IDLE);
  assign dbg_start  = loaded && dbg_connect_in && !dbg_conn_q && !dbg_busy_q;
  assign boot_try   = boot_id_valid_in && (boot_q == BOOT_AUTH) && !boot_done;
  assign boot_fail  = boot_done && !boot_match && (boot_q == BOOT_AUTH);
  // third successive failure locks into erase-ready
  assign lock_trip  = boot_fail && (mode == MODE_BOOT_LOCK) && (fail_q == FAIL_LIMIT - 2'h1);

  always_comb begin
    boot_d = boot_q;
    fail_d = fail_q;
    case (boot_q)
      BOOT_IDLE: begin
        if (boot_start) begin
          if (mode == MODE_OPEN && flash_blank_in)
            boot_d = BOOT_FULL;
          else if (mode == MODE_OPEN || mode == MODE_DBG_AUTH)
            boot_d = BOOT_ERASE_RDY;
          else
            boot_d = BOOT_AUTH;
        end
      end
      BOOT_AUTH: begin
        if (boot_done && boot_match) begin
          boot_d = BOOT_FULL;
          fail_d = FAIL_RST;
        end else if (lock_trip) begin
          boot_d = BOOT_ERASE_RDY;
          fail_d = FAIL_RST;
        end else if (boot_fail && mode == MODE_BOOT_LOCK) begin
          fail_d = fail_q + 2'h1;
        end
      end
      BOOT_ERASE_RDY: begin
        // full access only after whole erase
        if (all_erased_in)
          boot_d = BOOT_FULL;
      end
      BOOT_FULL: boot_d = BOOT_FULL;
      default:   boot_d = BOOT_IDLE;
    endcase
    // the erase-ready lock survives a session end, unlike a pending auth
    if (session_end_in && boot_d != BOOT_ERASE_RDY) begin
      boot_d = BOOT_IDLE;
      fail_d = (boot_q == BOOT_AUTH) ? fail_d : FAIL_RST;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boot_q <= BOOT_IDLE;
      fail_q <= FAIL_RST;
    end else begin
      boot_q <= boot_d;
      fail_q <= fail_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open mode connects at once; otherwise on match only
  assign dbg_conn_d = session_end_in ? 1'b0 :
                      (dbg_start && mode == MODE_OPEN) ? 1'b1 :
                      (dbg_done && dbg_match) ? 1'b1 : dbg_conn_q;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dbg_conn_q      <= 1'b0;
      dbg_busy_q      <= 1'b0;
      dbg_refuse_out  <= 1'b0;
      boot_refuse_out <= 1'b0;
    end else begin
      dbg_conn_q      <= dbg_conn_d;
      dbg_busy_q      <= dbg_start && mode != MODE_OPEN;
      // refuse and wait for a fresh attempt; open mode never refuses, the id is not checked there
      dbg_refuse_out  <= dbg_done && dbg_busy_q && !dbg_match;
      boot_refuse_out <= boot_fail;
    end
  end

  assign dbg_conn_out       = dbg_conn_q;
  assign read_ok_out        = (boot_q == BOOT_FULL);
  assign prog_ok_out        = (boot_q == BOOT_FULL);
  assign erase_ok_out       = (boot_q == BOOT_FULL) || (boot_q == BOOT_ERASE_RDY);
  assign erase_ready_out    = (boot_q == BOOT_ERASE_RDY);
  assign boot_auth_wait_out = (boot_q == BOOT_AUTH);

  ////////////////////////////////////////////////////////////////////////////
  property p_open_decode;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (mode == MODE_OPEN) == ((ctrl_code == CTRL_OPEN) && id_all_open);
  endproperty
  a_open_decode: assert property (p_open_decode) else $error("open mode decode wrong");

  property p_blank_full;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      boot_start && mode == MODE_OPEN && flash_blank_in && !session_end_in |=> read_ok_out && prog_ok_out;
  endproperty
  a_blank_full: assert property (p_blank_full) else $error("blank open boot not full");

  property p_data_erase;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      boot_start && mode == MODE_OPEN && !flash_blank_in |=> erase_ready_out && !read_ok_out && !prog_ok_out;
  endproperty
  a_data_erase: assert property (p_data_erase) else $error("open boot with data not erase-ready");

  property p_erase_hold;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      erase_ready_out && !all_erased_in |=> erase_ready_out && !read_ok_out && !prog_ok_out;
  endproperty
  a_erase_hold: assert property (p_erase_hold) else $error("erase-ready left before full erase");

  property p_dbg_open;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      dbg_start && mode == MODE_OPEN && !session_end_in |=> dbg_conn_out;
  endproperty
  a_dbg_open: assert property (p_dbg_open) else $error("open debugger not accepted at once");

  property p_mode_sel;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      !is_open && ctrl_code != CTRL_BOOT_LCK && ctrl_code != CTRL_BOOT_ID |-> mode == MODE_DBG_AUTH;
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("debugger-auth mode not selected");

  property p_dbg_mode_boot;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      boot_start && mode == MODE_DBG_AUTH |=> erase_ready_out && !boot_auth_wait_out;
  endproperty
  a_dbg_mode_boot: assert property (p_dbg_mode_boot) else $error("boot not erase-ready in debugger-auth mode");

  property p_dbg_match;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      dbg_start && mode != MODE_OPEN && !session_end_in ##1 !session_end_in |=>
        dbg_conn_out == $past(dbg_match);
  endproperty
  a_dbg_match: assert property (p_dbg_match) else $error("debugger connect not tied to id match");

  property p_dbg_refuse;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      dbg_done && !dbg_match && !dbg_conn_out && mode != MODE_OPEN && $past(mode != MODE_OPEN) |=>
        dbg_refuse_out && !dbg_conn_out && $stable(boot_q);
  endproperty
  a_dbg_refuse: assert property (p_dbg_refuse) else $error("debugger mismatch handled wrongly");

  property p_lockout;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      boot_fail && mode == MODE_BOOT_LOCK && fail_q == 2'h2 && !all_erased_in |=> erase_ready_out;
  endproperty
  a_lockout: assert property (p_lockout) else $error("third boot mismatch did not lock");

  property p_no_early;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      !loaded |=> !dbg_conn_out && boot_q == BOOT_IDLE;
  endproperty
  a_no_early: assert property (p_no_early) else $error("access before codes latched");

  c_dbg_auth_ok:  cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
                    mode == MODE_DBG_AUTH && dbg_done && dbg_match);
  c_lockout:      cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) lock_trip);
  c_erase_unlock: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
                    erase_ready_out ##1 read_ok_out);
endmodule // fap_gate

// file: src/fap_pkg.sv
// constants and types shared by the flash access protection gate
package fap_pkg;
  localparam int          ID_BYTES      = 15;
  localparam int          ID_BITS       = ID_BYTES * 8;
  localparam logic [7:0]  CTRL_OPEN     = 8'hff;
  localparam logic [7:0]  ID_BYTE_OPEN  = 8'hff;
  localparam logic [7:0]  CTRL_BOOT_LCK = 8'h45;
  localparam logic [7:0]  CTRL_BOOT_ID  = 8'h52;
  localparam logic [1:0]  FAIL_LIMIT    = 2'h3;
  localparam logic [1:0]  FAIL_RST      = 2'h0;
  localparam logic [7:0]  CTRL_RST      = 8'h00;

  typedef enum logic [1:0] {
    MODE_OPEN,
    MODE_DBG_AUTH,
    MODE_BOOT_LOCK,
    MODE_BOOT_AUTH
  } fap_mode_t;

  typedef enum logic [1:0] {
    BOOT_IDLE,
    BOOT_AUTH,
    BOOT_ERASE_RDY,
    BOOT_FULL
  } fap_boot_t;
endpackage

// file: src/fap_id_store.sv
// latched protection codes and registered id comparators
`timescale 1ns/10ps
module fap_id_store
  import fap_pkg::*;
(
  // clock and reset
  input  wire logic               ref_clk_in,
  input  wire logic               rst_n_in,
  // stored codes
  input  wire logic               load_in,
  input  wire logic [7:0]         ctrl_code_in,
  input  wire logic [ID_BITS-1:0] id_code_in,
  // candidate ids
  input  wire logic               dbg_valid_in,
  input  wire logic [ID_BITS-1:0] dbg_id_in,
  input  wire logic               boot_valid_in,
  input  wire logic [ID_BITS-1:0] boot_id_in,
  // results
  output logic                    loaded_out,
  output logic [7:0]              ctrl_code_out,
  output logic                    id_all_open_out,
  output logic                    dbg_done_out,
  output logic                    dbg_match_out,
  output logic                    boot_done_out,
  output logic                    boot_match_out
);
  logic [ID_BITS-1:0] id_q;
  logic [ID_BYTES-1:0] dbg_eq;
  logic [ID_BYTES-1:0] boot_eq;
  logic [ID_BYTES-1:0] open_eq;

  for (genvar b = 0; b < ID_BYTES; b++) begin : g_byte
    assign dbg_eq[b]  = (dbg_id_in[b*8 +: 8] == id_q[b*8 +: 8]);
    assign boot_eq[b] = (boot_id_in[b*8 +: 8] == id_q[b*8 +: 8]);
    assign open_eq[b] = (id_q[b*8 +: 8] == ID_BYTE_OPEN);
  end

  assign id_all_open_out = &open_eq;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      id_q           <= '0;
      ctrl_code_out  <= CTRL_RST;
      loaded_out     <= 1'b0;
    end else if (load_in) begin
      id_q           <= id_code_in;
      ctrl_code_out  <= ctrl_code_in;
      loaded_out     <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dbg_done_out   <= 1'b0;
      dbg_match_out  <= 1'b0;
      boot_done_out  <= 1'b0;
      boot_match_out <= 1'b0;
    end else begin
      dbg_done_out   <= dbg_valid_in;
      dbg_match_out  <= &dbg_eq;
      boot_done_out  <= boot_valid_in;
      boot_match_out <= &boot_eq;
    end
  end
endmodule // fap_id_store

// file: testbench/fap_host_model.sv
// partner model: boot-mode host and on-chip debugger requests
`timescale 1ns/10ps
module fap_host_model
  import fap_pkg::*;
(
  // clock
  input  wire logic         ref_clk_in,
  // boot-mode host
  output logic              boot_connect_out,
  output logic              boot_id_valid_out,
  output logic [ID_BITS-1:0] boot_id_out,
  // debugger
  output logic              dbg_connect_out,
  output logic [ID_BITS-1:0] dbg_id_out
);
  initial begin
    boot_connect_out  = 1'b0;
    boot_id_valid_out = 1'b0;
    boot_id_out       = '0;
    dbg_connect_out   = 1'b0;
    dbg_id_out        = '0;
  end

  task automatic boot_conn();
    @(posedge ref_clk_in);
    boot_connect_out <= 1'b1;
    @(posedge ref_clk_in);
    boot_connect_out <= 1'b0;
  endtask

  task automatic boot_try(input logic [ID_BITS-1:0] id);
    @(posedge ref_clk_in);
    boot_id_valid_out <= 1'b1;
    boot_id_out       <= id;
    @(posedge ref_clk_in);
    boot_id_valid_out <= 1'b0;
    // stale id would hide a late sample, so show its inverse
    boot_id_out       <= ~id;
  endtask

  task automatic dbg_try(input logic [ID_BITS-1:0] id, input int gap);
    repeat (gap) @(posedge ref_clk_in);
    @(posedge ref_clk_in);
    dbg_connect_out <= 1'b1;
    dbg_id_out      <= id;
    @(posedge ref_clk_in);
    dbg_connect_out <= 1'b0;
    dbg_id_out      <= ~id;
  endtask
endmodule // fap_host_model

// file: testbench/test_flash_access_protection_gate.sv
// self-checking testbench for the flash access protection gate
`timescale 1ns/10ps
module test_flash_access_protection_gate;
  import fap_pkg::*;
  localparam logic [ID_BITS-1:0] KEY = 120'h0123456789abcdef0123456789abcd;
  localparam logic [ID_BITS-1:0] ALL_FF = {15{8'hff}};
  logic ref_clk, rst_n, cfg_load, blank, erased, sess, br, dr;
  logic [7:0] ctrl;
  logic [ID_BITS-1:0] idc;
  wire bc, bv, dc, rd, pg, er, erdy, aw, brf, dcn, drf;
  wire [ID_BITS-1:0] bid, did;
  wire [1:0] mode;
  wire [5:0] st = {rd, pg, er, erdy, aw, dcn};
  int errors = 0;
  int samples_checked = 0;

  always #2.5 ref_clk = ~ref_clk;

  fap_host_model host (.ref_clk_in(ref_clk), .boot_connect_out(bc), .boot_id_valid_out(bv),
    .boot_id_out(bid), .dbg_connect_out(dc), .dbg_id_out(did));
  fap_gate dut (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .cfg_load_in(cfg_load), .ctrl_code_in(ctrl),
    .id_code_in(idc), .flash_blank_in(blank), .all_erased_in(erased), .boot_connect_in(bc),
    .boot_id_valid_in(bv), .boot_id_in(bid), .dbg_connect_in(dc), .dbg_id_in(did),
    .session_end_in(sess), .read_ok_out(rd), .prog_ok_out(pg), .erase_ok_out(er),
    .erase_ready_out(erdy), .boot_auth_wait_out(aw), .boot_refuse_out(brf), .dbg_conn_out(dcn),
    .dbg_refuse_out(drf), .mode_out(mode));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // pulses are gathered each cycle so a one-cycle refuse is never missed
  task automatic obs(input int n);
    br = 1'b0;
    dr = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      br = br | brf;
      dr = dr | drf;
    end
  endtask

  task automatic do_reset(input logic b);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    blank <= b;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    obs(1);
  endtask

  task automatic setup(input logic [7:0] c, input logic [ID_BITS-1:0] id, input logic b);
    do_reset(b);
    @(posedge ref_clk);
    cfg_load <= 1'b1;
    ctrl     <= c;
    idc      <= id;
    @(posedge ref_clk);
    cfg_load <= 1'b0;
    obs(2);
  endtask

  task automatic pulse_erased();
    @(posedge ref_clk);
    erased <= 1'b1;
    @(posedge ref_clk);
    erased <= 1'b0;
    obs(2);
  endtask

  task automatic t_codes();
    logic [7:0] cc [8] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h44, 8'h45, 8'h52, 8'h53};
    logic [1:0] mm [8] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h3, 2'h1};
    for (int i = 0; i < 8; i++) begin
      setup(cc[i], ALL_FF ^ ((i == 1) ? {8'h01, {14{8'h00}}} : (i == 2) ? 120'h1 : 120'h0), 1'b1);
      chk(mode, mm[i]);
    end
    $display("t_codes done");
  endtask

  task automatic t_no_load();
    do_reset(1'b1);
    chk({mode, st}, 8'h40);
    host.dbg_try('0, 0);
    host.boot_conn();
    obs(4);
    chk({dr, st}, 7'h00);
    $display("t_no_load done");
  endtask

  task automatic t_open(input logic b);
    setup(8'hff, ALL_FF, b);
    host.boot_conn();
    obs(2);
    chk(st, b ? 6'b111000 : 6'b001100);
    host.dbg_try(KEY, 0);
    obs(3);
    chk({dr, st}, b ? 7'b0111001 : 7'b0001101);
    if (!b) begin
      pulse_erased();
      chk(st, 6'b111001);
    end
    @(posedge ref_clk);
    sess <= 1'b1;
    @(posedge ref_clk);
    sess <= 1'b0;
    obs(2);
    chk(st, 6'b000000);
    $display("t_open done");
  endtask

  task automatic t_dbg_auth();
    setup(8'h00, KEY, 1'b1);
    host.dbg_try(KEY ^ {8'h80, {14{8'h00}}}, 0);
    obs(4);
    chk({dr, st}, 7'b1000000);
    host.dbg_try(KEY ^ 120'h1, 2);
    obs(4);
    chk({dr, st}, 7'b1000000);
    host.dbg_try(KEY, 0);
    obs(4);
    chk({dr, st}, 7'b0000001);
    host.boot_conn();
    obs(2);
    chk(st, 6'b001101);
    pulse_erased();
    chk(st, 6'b111001);
    $display("t_dbg_auth done");
  endtask

  task automatic t_boot(input logic [7:0] c, input logic three);
    setup(c, KEY, 1'b0);
    host.boot_conn();
    obs(2);
    chk(st, 6'b000010);
    repeat (2) begin
      host.boot_try(~KEY);
      obs(4);
      chk({br, st}, 7'b1000010);
    end
    host.boot_try(three ? (KEY ^ 120'h1) : KEY);
    obs(4);
    chk(st, three ? ((c == CTRL_BOOT_LCK) ? 6'b001100 : 6'b000010) : 6'b111000);
    $display("t_boot done");
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("watchdog expired");
    give_verdict();
  end

  initial begin
    ref_clk  = 1'b0;
    rst_n    = 1'b0;
    cfg_load = 1'b0;
    blank    = 1'b0;
    erased   = 1'b0;
    sess     = 1'b0;
    ctrl     = 8'h00;
    idc      = '0;
    t_no_load();
    t_codes();
    t_open(1'b1);
    t_open(1'b0);
    t_dbg_auth();
    t_boot(8'h45, 1'b1);
    t_boot(8'h45, 1'b0);
    t_boot(8'h52, 1'b1);
    give_verdict();
  end
endmodule // test_flash_access_protection_gate
